// ---- core/fsp_core.sv ----
// Suspend/resume, power-down and ID read command block of a serial flash
//
// What this block does
// - Suspend accepted only with flag clear, busy set, erase or program running.
// - Suspend is ignored while a whole-chip erase runs.
// - While erase suspended, status write and erase operations are refused.
// - While program suspended, status write and program operations are refused.
// - Program suspend only applies to single or quad page program.
// - Accepted suspend sets the flag at once, busy drops within suspend latency.
// - Reset clears the suspend flag; a following resume is ignored.
// - Resume accepted only with flag set and busy clear.
// - Accepted resume clears flag, raises busy within 200 ns, finishes the job.
// - Power-down needs chip select high right after bit eight; entry after latency.
// - In power-down only the release command is recognised.
// - After reset the device is in normal operation.
// - Release command wakes the device after the release latency.
// - ID read takes three dummy bytes, then device ID repeated, MSB first.
// - Release with ID read wakes the device after the second release latency.
// - Release/ID command is ignored while busy; running cycle unaffected.
// - Command 90h with zero address sends manufacturer then device ID.
// - Command 92h: two-bit address and output, mode Fxh, IDs alternate.
// - Command 94h: four dummy clocks, four-bit address and output, mode Fxh.
// - Four-byte address mode lengthens dual and quad ID address to 32 bits.
// - Busy stays set while an internal cycle runs, clears when it ends.
`timescale 1ns/10ps
`default_nettype none

module fsp_core #(
  parameter logic [7:0] MFR_ID = 8'hA5,  // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3C   // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  input wire logic addr4_mode,
  input wire logic op_start,
  input wire fsp_pkg::fsp_op_t op_kind,
  input wire logic [31:0] op_cycles,
  output logic busy,
  output logic suspend_flag,
  output logic powered_down,
  output logic cmds_enabled,
  output logic op_done
);
  import fsp_pkg::*;

  localparam int A_SUSPEND = SUSPEND_CYC + 1;
  localparam int A_DP = DP_CYC + 1;
  localparam int A_RES2 = RES2_CYC + 1;
  localparam int A_RES1 = RES1_CYC + 1;

  function automatic logic [6:0] out_start(input logic [7:0] c, input logic a4);
    logic [6:0] s;
    s = CNT_SAT;
    if (c == CMD_RELEASE_ID || c == CMD_ID_SINGLE)
      s = SINGLE_ID_START;
    else if (c == CMD_ID_DUAL)
      s = CMD_BITS + (a4 ? DUAL_ADDR4_CLKS : DUAL_ADDR3_CLKS) + DUAL_MODE_CLKS;
    else if (c == CMD_ID_QUAD)
      s = CMD_BITS + QUAD_DUMMY_CLKS + (a4 ? QUAD_ADDR4_CLKS : QUAD_ADDR3_CLKS)
          + QUAD_MODE_CLKS;
    return s;
  endfunction : out_start

  function automatic logic [2:0] bus_width(input logic [7:0] c);
    logic [2:0] w;
    w = 3'h1;
    if (c == CMD_ID_DUAL)
      w = 3'h2;
    else if (c == CMD_ID_QUAD)
      w = 3'h4;
    return w;
  endfunction : bus_width

  function automatic logic suspendable(input fsp_op_t k);
    return k == OP_SECT_ERASE || k == OP_PAGE_PROG || k == OP_QUAD_PROG;
  endfunction : suspendable

  function automatic logic refused(input fsp_op_t k, input fsp_op_t held);
    logic r;
    r = 1'b0;
    if (held == OP_SECT_ERASE)
      r = k == OP_SECT_ERASE || k == OP_CHIP_ERASE || k == OP_STATUS_WR;
    else if (held == OP_PAGE_PROG || held == OP_QUAD_PROG)
      r = k == OP_PAGE_PROG || k == OP_QUAD_PROG || k == OP_STATUS_WR;
    return r;
  endfunction : refused

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: command capture and ID shifter

  fsp_pwr_t pw_q;
  logic busy_q;
  logic [6:0] cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] in_q;
  logic [7:0] in_d;
  logic nz_q;
  logic go_q;
  logic [3:0] idx_q;
  logic [3:0] out_q;
  logic [3:0] oe_n_q;
  logic [7:0] fr_op_q;
  logic fr_x8_q;
  logic fr_tog_q;
  logic pd_m_q, pd_s_q, bz_m_q, bz_s_q, a4_m_q, a4_s_q;
  logic [6:0] start;
  logic [6:0] a_lo;
  logic [6:0] a_hi;
  logic [2:0] w;
  logic in_addr;
  logic id_ok;
  logic addr_nz;

  // State levels from the system side, static across a frame
  always_ff @(posedge spi_sck or posedge sys_rst)
    if (sys_rst)
    begin
      pd_m_q <= 1'b0;
      pd_s_q <= 1'b0;
      bz_m_q <= 1'b0;
      bz_s_q <= 1'b0;
      a4_m_q <= 1'b0;
      a4_s_q <= 1'b0;
    end
    else
    begin
      pd_m_q <= pw_q != PW_RUN;
      pd_s_q <= pd_m_q;
      bz_m_q <= busy_q;
      bz_s_q <= bz_m_q;
      a4_m_q <= addr4_mode;
      a4_s_q <= a4_m_q;
    end

  assign start = out_start(cmd_q, a4_s_q);
  assign w = (cnt_q < CMD_BITS) ? 3'h1 : bus_width(cmd_q);
  assign a_lo = (cmd_q == CMD_ID_QUAD) ? CMD_BITS + QUAD_DUMMY_CLKS : CMD_BITS;
  assign a_hi = start - ((cmd_q == CMD_ID_DUAL) ? DUAL_MODE_CLKS :
                         (cmd_q == CMD_ID_QUAD) ? QUAD_MODE_CLKS : 7'h00);
  assign in_addr = cnt_q >= a_lo && cnt_q < a_hi && cmd_q != CMD_RELEASE_ID;
  // Only the bits taken on this clock, not leftover command bits
  assign addr_nz = (w == 3'h4) ? io_in[3:0] != 4'h0 :
                   (w == 3'h2) ? io_in[1:0] != 2'h0 : io_in[0];

  always_comb
  begin
    in_d = {in_q[6:0], io_in[0]};
    if (w == 3'h2)
      in_d = {in_q[5:0], io_in[1:0]};
    else if (w == 3'h4)
      in_d = {in_q[3:0], io_in[3:0]};
  end

  // Device-ID read refused while busy, others while powered down
  assign id_ok = (cmd_q == CMD_RELEASE_ID) ? !bz_s_q : !pd_s_q;

  // Frame state, cleared by chip select high
  always_ff @(posedge spi_sck or posedge spi_cs_n)
    if (spi_cs_n)
    begin
      cnt_q <= 7'h00;
      cmd_q <= 8'h00;
      in_q <= 8'h00;
      nz_q <= 1'b0;
      go_q <= 1'b0;
    end
    else
    begin
      if (cnt_q != CNT_SAT)
        cnt_q <= cnt_q + 7'h01;
      if (cnt_q < CMD_BITS)
        cmd_q <= {cmd_q[6:0], io_in[0]};
      in_q <= in_d;
      if (in_addr && addr_nz)
        nz_q <= 1'b1;
      // Last input clock: dummies, address and mode done
      if (cnt_q == start - 7'h01 && cnt_q >= CMD_BITS && id_ok && !nz_q
          && !(in_addr && addr_nz)
          && (bus_width(cmd_q) == 3'h1 || in_d[7:4] == MODE_HI_OK))
        go_q <= 1'b1;
    end

  // Output shifter on falling edges, wraps to alternate the IDs
  always_ff @(negedge spi_sck or posedge spi_cs_n)
    if (spi_cs_n)
    begin
      idx_q <= 4'h0;
      out_q <= 4'h0;
      oe_n_q <= 4'hF;
    end
    else if (go_q)
    begin
      logic [15:0] word;
      logic [15:0] sh;
      word = (cmd_q == CMD_RELEASE_ID) ? {DEV_ID, DEV_ID} : {MFR_ID, DEV_ID};
      sh = word << idx_q;
      idx_q <= idx_q + {1'b0, bus_width(cmd_q)};
      if (bus_width(cmd_q) == 3'h4)
      begin
        out_q <= sh[15:12];
        oe_n_q <= 4'h0;
      end
      else if (bus_width(cmd_q) == 3'h2)
      begin
        out_q <= {2'b00, sh[15:14]};
        oe_n_q <= 4'hC;
      end
      else
      begin
        out_q <= {2'b00, sh[15], 1'b0};
        oe_n_q <= 4'hD;
      end
    end

  assign io_out = out_q;
  assign io_oe_n = oe_n_q;

  // Frame summary kept across chip select high
  always_ff @(posedge spi_sck or posedge sys_rst)
    if (sys_rst)
    begin
      fr_op_q <= 8'h00;
      fr_x8_q <= 1'b0;
      fr_tog_q <= 1'b0;
    end
    else if (!spi_cs_n)
    begin
      if (cnt_q == CMD_BITS - 7'h01)
      begin
        fr_op_q <= {cmd_q[6:0], io_in[0]};
        fr_x8_q <= 1'b1;
        fr_tog_q <= ~fr_tog_q;
      end
      else if (cnt_q == CMD_BITS)
        fr_x8_q <= 1'b0;
    end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: frame end detection

  logic cs_m_q, cs_s_q, cs_p_q, tg_m_q, tg_s_q, seen_q;
  logic ev;
  logic x8;
  logic run;

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_p_q <= 1'b1;
      tg_m_q <= 1'b0;
      tg_s_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      cs_m_q <= spi_cs_n;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      tg_m_q <= fr_tog_q;
      tg_s_q <= tg_m_q;
      if (cs_s_q && !cs_p_q)
        seen_q <= tg_s_q;
    end

  // Summary is quiet by now: link clock idle while chip select high
  assign ev = cs_s_q && !cs_p_q && tg_s_q != seen_q;
  assign x8 = fr_x8_q;
  assign run = pw_q == PW_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // Power-down state machine

  logic [15:0] lat_q;

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      pw_q <= PW_RUN;
      lat_q <= LAT_RST;
    end
    else
      unique case (pw_q)
        PW_RUN:
          if (ev && x8 && fr_op_q == CMD_PWRDN && !busy_q)
          begin
            pw_q <= PW_ENTER;
            lat_q <= 16'(DP_CYC - 1);
          end
        PW_ENTER:
          if (lat_q == LAT_RST)
            pw_q <= PW_DOWN;
          else
            lat_q <= lat_q - 16'h0001;
        PW_DOWN:
          if (ev && fr_op_q == CMD_RELEASE_ID)
          begin
            pw_q <= PW_WAKE;
            lat_q <= x8 ? 16'(RES1_CYC - 1) : 16'(RES2_CYC - 1);
          end
        PW_WAKE:
          if (lat_q == LAT_RST)
            pw_q <= PW_RUN;
          else
            lat_q <= lat_q - 16'h0001;
      endcase

  ////////////////////////////////////////////////////////////////////////////
  // Operation timer with suspend and resume

  fsp_op_t kind_q, skind_q;
  logic [31:0] rem_q, srem_q;
  logic susp_q, spend_q, done_q;
  logic [15:0] scnt_q;
  logic c_suspend, c_res, suspend_ok;

  assign c_suspend = ev && x8 && run && fr_op_q == CMD_SUSPEND;
  assign c_res = ev && x8 && run && fr_op_q == CMD_RESUME;
  assign suspend_ok = busy_q && !susp_q && suspendable(kind_q);

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      susp_q <= 1'b0;
      spend_q <= 1'b0;
      done_q <= 1'b0;
      kind_q <= OP_NONE;
      skind_q <= OP_NONE;
      rem_q <= REM_RST;
      srem_q <= REM_RST;
      scnt_q <= LAT_RST;
    end
    else
    begin
      done_q <= 1'b0;
      if (busy_q && rem_q != REM_RST)
        rem_q <= rem_q - 32'h1;
      if (c_suspend && suspend_ok)
      begin
        susp_q <= 1'b1;
        spend_q <= 1'b1;
        scnt_q <= 16'(SUSPEND_CYC - 1);
      end
      else if (spend_q)
      begin
        scnt_q <= scnt_q - 16'h0001;
        if (scnt_q == LAT_RST || rem_q <= 32'h1)
        begin
          busy_q <= 1'b0;
          spend_q <= 1'b0;
          skind_q <= kind_q;
          srem_q <= rem_q;
          kind_q <= OP_NONE;
        end
      end
      else if (busy_q && rem_q <= 32'h1)
      begin
        busy_q <= 1'b0;
        kind_q <= OP_NONE;
        done_q <= 1'b1;
      end
      else if (c_res && susp_q && !busy_q)
      begin
        susp_q <= 1'b0;
        busy_q <= 1'b1;
        kind_q <= skind_q;
        rem_q <= (srem_q == REM_RST) ? 32'h1 : srem_q;
        skind_q <= OP_NONE;
      end
      else if (op_start && !busy_q && run && !(susp_q && refused(op_kind, skind_q)))
      begin
        busy_q <= 1'b1;
        kind_q <= op_kind;
        rem_q <= (op_cycles == REM_RST) ? 32'h1 : op_cycles;
      end
    end

  assign busy = busy_q;
  assign suspend_flag = susp_q;
  assign powered_down = pw_q == PW_DOWN;
  assign cmds_enabled = run;
  assign op_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_suspend_take;
    @(posedge clk) disable iff (sys_rst)
    c_suspend && busy_q && !susp_q && suspendable(kind_q) |=> susp_q && spend_q;
  endproperty
  a_suspend_take: assert property (p_suspend_take)
    else $error("suspend not taken");

  property p_suspend_chip;
    @(posedge clk) disable iff (sys_rst)
    c_suspend && !susp_q && kind_q == OP_CHIP_ERASE |=> !susp_q;
  endproperty
  a_suspend_chip: assert property (p_suspend_chip)
    else $error("suspend during chip erase");

  property p_suspend_idle;
    @(posedge clk) disable iff (sys_rst)
    c_suspend && !busy_q && !susp_q |=> !susp_q && !busy_q;
  endproperty
  a_suspend_idle: assert property (p_suspend_idle)
    else $error("suspend taken while idle");

  property p_busy_drop;
    @(posedge clk) disable iff (sys_rst)
    $rose(susp_q) |-> ##[0:A_SUSPEND] !busy_q;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("busy late after suspend");

  property p_res_take;
    @(posedge clk) disable iff (sys_rst)
    c_res && susp_q && !busy_q |=> !susp_q ##0 busy_q [*2];
  endproperty
  a_res_take: assert property (p_res_take)
    else $error("resume not taken");

  property p_res_busy;
    @(posedge clk) disable iff (sys_rst)
    c_res && busy_q |=> susp_q == $past(susp_q);
  endproperty
  a_res_busy: assert property (p_res_busy)
    else $error("resume taken while busy");

  property p_pd_entry;
    @(posedge clk) disable iff (sys_rst)
    $rose(pw_q == PW_ENTER) |-> ##[1:A_DP] pw_q == PW_DOWN;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("power-down entry late");

  property p_pd_stay;
    @(posedge clk) disable iff (sys_rst)
    pw_q == PW_DOWN && !(ev && fr_op_q == CMD_RELEASE_ID) |=> pw_q == PW_DOWN;
  endproperty
  a_pd_stay: assert property (p_pd_stay)
    else $error("power-down left without release");

  property p_wake_id;
    @(posedge clk) disable iff (sys_rst)
    pw_q == PW_DOWN && ev && !x8 && fr_op_q == CMD_RELEASE_ID
      |=> !run [*8] ##[1:A_RES2] run;
  endproperty
  a_wake_id: assert property (p_wake_id)
    else $error("release with ID latency wrong");

  property p_wake;
    @(posedge clk) disable iff (sys_rst)
    pw_q == PW_DOWN && ev && x8 && fr_op_q == CMD_RELEASE_ID |=> ##[1:A_RES1] run;
  endproperty
  a_wake: assert property (p_wake)
    else $error("release latency too long");

endmodule : fsp_core

`default_nettype wire

// ---- core/fsp_pkg.sv ----
// Constants and types shared by the suspend, power-down and ID command block
package fsp_pkg;

  // Command codes
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_PWRDN = 8'hB9;
  localparam logic [7:0] CMD_RELEASE_ID = 8'hAB;
  localparam logic [7:0] CMD_ID_SINGLE = 8'h90;
  localparam logic [7:0] CMD_ID_DUAL = 8'h92;
  localparam logic [7:0] CMD_ID_QUAD = 8'h94;
  localparam logic [3:0] MODE_HI_OK = 4'hF;

  // Link frame layout, in link clocks
  localparam logic [6:0] CMD_BITS = 7'h08;
  localparam logic [6:0] SINGLE_ID_START = 7'h20;
  localparam logic [6:0] DUAL_ADDR3_CLKS = 7'h0C;
  localparam logic [6:0] DUAL_ADDR4_CLKS = 7'h10;
  localparam logic [6:0] DUAL_MODE_CLKS = 7'h04;
  localparam logic [6:0] QUAD_DUMMY_CLKS = 7'h04;
  localparam logic [6:0] QUAD_ADDR3_CLKS = 7'h06;
  localparam logic [6:0] QUAD_ADDR4_CLKS = 7'h08;
  localparam logic [6:0] QUAD_MODE_CLKS = 7'h02;
  localparam logic [6:0] CNT_SAT = 7'h7F;

  // Timing, system clock 100 MHz
  localparam int CLK_NS = 10;
  localparam int SUSPEND_NS = 5000;
  localparam int RES_BUSY_NS = 200;
  localparam int DP_NS = 3000;
  localparam int RES1_NS = 3000;
  localparam int RES2_NS = 1800;
  // Longest times round down, least times round up
  localparam int SUSPEND_CYC = (SUSPEND_NS / CLK_NS < 1) ? 1 : SUSPEND_NS / CLK_NS;
  localparam int RES_BUSY_CYC = (RES_BUSY_NS / CLK_NS < 1) ? 1 : RES_BUSY_NS / CLK_NS;
  localparam int DP_CYC = (DP_NS / CLK_NS < 1) ? 1 : DP_NS / CLK_NS;
  localparam int RES1_CYC = (RES1_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES2_CYC = (RES2_NS + CLK_NS - 1) / CLK_NS;

  // Reset values
  localparam logic [15:0] LAT_RST = 16'h0000;
  localparam logic [31:0] REM_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    PW_RUN = 2'b00,
    PW_ENTER = 2'b01,
    PW_DOWN = 2'b10,
    PW_WAKE = 2'b11
  } fsp_pwr_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SECT_ERASE = 3'b001,
    OP_CHIP_ERASE = 3'b010,
    OP_PAGE_PROG = 3'b011,
    OP_QUAD_PROG = 3'b100,
    OP_STATUS_WR = 3'b101
  } fsp_op_t;

endpackage : fsp_pkg

// ---- testbench/fsp_core_tb_top.sv ----
// Self-checking bench for the suspend, power-down and ID command block
`timescale 1ns/10ps
`default_nettype none

module fsp_core_tb_top;
  import fsp_pkg::*;
  localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary value
  logic clk, sys_rst, spi_sck, spi_cs_n, addr4_mode, op_start;
  logic [3:0] io_in, io_out, io_oe_n;
  fsp_op_t op_kind;
  logic [31:0] op_cycles;
  logic busy, suspend_flag, powered_down, cmds_enabled, op_done;
  logic [63:0] rx;
  int n_mismatch, n_tests, seed, m_busy, m_suspend, m_pd, m_en, m_kind;

  fsp_core #(.MFR_ID(MFR), .DEV_ID(DEV)) DUT (.clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .addr4_mode(addr4_mode), .op_start(op_start), .op_kind(op_kind), .op_cycles(op_cycles),
    .busy(busy), .suspend_flag(suspend_flag), .powered_down(powered_down),
    .cmds_enabled(cmds_enabled), .op_done(op_done));

  fsp_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk_bit(input logic got, input int exp);
    n_tests++;
    if (got !== exp[0])
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp[0]);
    end
  endtask : chk_bit

  task automatic chk_id(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_id

  task automatic chk_st();
    if (m_busy >= 0)
      chk_bit(busy, m_busy);
    chk_bit(suspend_flag, m_suspend);
    chk_bit(powered_down, m_pd);
    chk_bit(cmds_enabled, m_en);
  endtask : chk_st

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus with model update
  task automatic op(input int k, input int cyc);
    @(posedge clk);
    op_kind <= fsp_op_t'(k);
    op_cycles <= cyc;
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
    if (m_busy == 0 && m_en == 1 && m_suspend == 0)
    begin
      m_busy = 1;
      m_kind = k;
    end
    repeat (3) @(negedge clk);
    chk_st();
  endtask : op

  task automatic done();
    for (int i = 0; i < 4000 && op_done !== 1'b1; i++)
      @(negedge clk);
    chk_bit(op_done, 1);
    m_busy = 0;
    repeat (2) @(negedge clk);
    chk_st();
  endtask : done

  task automatic cmd(input logic [7:0] c, input int n);
    int acc;
    acc = 0;
    host.frame(c, n, 0, 0, 99, 1, rx);
    repeat (8) @(negedge clk);
    if (m_en == 1 && n == 8 && c == CMD_SUSPEND && m_busy == 1 && m_suspend == 0)
      acc = (m_kind != 2 && m_kind != 5) ? 1 : 0;
    if (m_en == 1 && n == 8 && c == CMD_RESUME && m_suspend == 1 && m_busy == 0)
      acc = 2;
    if (m_en == 1 && n == 8 && c == CMD_PWRDN && m_busy == 0)
      acc = 3;
    if (c == CMD_RELEASE_ID && m_pd == 1)
      acc = 4;
    if (acc == 1)
    begin
      m_suspend = 1;
      m_busy = -1;
    end
    if (acc == 2)
    begin
      m_suspend = 0;
      m_busy = 1;
    end
    if (acc > 2)
      m_en = 0;
    if (acc == 4)
      m_pd = 0;
    chk_st();
    if (acc == 1)
      repeat (SUSPEND_CYC) @(negedge clk);
    if (acc == 1)
      m_busy = 0;
    if (acc == 3)
      repeat (DP_CYC + 10) @(negedge clk);
    if (acc == 3)
      m_pd = 1;
    if (acc == 4)
    begin
      // About 48 cycles of the latency are gone already
      repeat (((n == 8) ? RES1_CYC : RES2_CYC) - 60) @(negedge clk);
      chk_st();
      repeat (30) @(negedge clk);
      m_en = 1;
    end
    if (acc == 1 || acc > 2)
      chk_st();
  endtask : cmd

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 91;
    sys_rst = 1'b0;
    op_start = 1'b0;
    op_kind = OP_NONE;
    op_cycles = 32'h0000_0000;
    addr4_mode = 1'b0;
    // Rising edge after time zero so the link-side resets see it
    #1 sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    {m_busy, m_suspend, m_pd, m_kind} = '0;
    m_en = 1;
    repeat (4) @(negedge clk);
    chk_st();
    cmd(CMD_SUSPEND, 8);
    cmd(CMD_RESUME, 8);
    host.frame(CMD_ID_SINGLE, 48, 8, 9, 32, 1, rx);
    chk_bit(host.drove, 0);
    host.frame(CMD_ID_DUAL, 40, 20, 20, 24, 2, rx);
    chk_bit(host.drove, 0);
    for (int a = 0; a < 2; a++)
    begin
      @(posedge clk);
      addr4_mode <= a[0];
      host.frame(CMD_RELEASE_ID, 48, 0, 0, 32, 1, rx);
      chk_id(rx, {48'h0, DEV, DEV});
      host.frame(CMD_ID_SINGLE, 48, 0, 0, 32, 1, rx);
      chk_id(rx, {48'h0, MFR, DEV});
      host.frame(CMD_ID_DUAL, 40 + 4 * a, 20 + 4 * a, 24 + 4 * a, 24 + 4 * a, 2, rx);
      chk_id(rx, {32'h0, MFR, DEV, MFR, DEV});
      host.frame(CMD_ID_QUAD, 28 + 2 * a, 18 + 2 * a, 20 + 2 * a, 20 + 2 * a, 4, rx);
      chk_id(rx, {32'h0, MFR, DEV, MFR, DEV});
    end
    op(1, 1500 + ($random(seed) & 255));
    host.frame(CMD_RELEASE_ID, 48, 0, 0, 32, 1, rx);
    chk_bit(host.drove, 0);
    cmd(CMD_SUSPEND, 8);
    op(1, 100);
    op(5, 100);
    cmd(CMD_SUSPEND, 8);
    cmd(CMD_RESUME, 8);
    repeat (SUSPEND_CYC) @(negedge clk);
    done();
    op(2, 1500 + ($random(seed) & 255));
    cmd(CMD_SUSPEND, 8);
    done();
    op(5, 1000 + ($random(seed) & 255));
    cmd(CMD_SUSPEND, 8);
    done();
    op(3, 1500 + ($random(seed) & 255));
    cmd(CMD_SUSPEND, 8);
    op(4, 100);
    op(5, 100);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    {m_busy, m_suspend} = '0;
    repeat (4) @(negedge clk);
    chk_st();
    cmd(CMD_RESUME, 8);
    cmd(CMD_PWRDN, 9);
    cmd(CMD_PWRDN, 8);
    host.frame(CMD_ID_SINGLE, 48, 0, 0, 32, 1, rx);
    chk_bit(host.drove, 0);
    cmd(CMD_RESUME, 8);
    cmd(CMD_RELEASE_ID, 8);
    cmd(CMD_PWRDN, 8);
    cmd(CMD_RELEASE_ID, 48);
    give_verdict();
  end

  initial
  begin
    #900000;
    n_mismatch++;
    give_verdict();
  end
endmodule : fsp_core_tb_top

`default_nettype wire

// ---- testbench/fsp_host.sv ----
// Host serial controller model that drives frames into the flash block
`timescale 1ns/10ps
`default_nettype none

module fsp_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n
);
  logic [3:0] drv_q;
  logic drove;

  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b0;
    drv_q = 4'h0;
    drove = 1'b0;
    // Rising edge after time zero clears the frame logic
    #1 spi_cs_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wire level, device enable wins over host value
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      io_in[b] = !io_oe_n[b] ? io_out[b] : drv_q[b];
  end

  always @(io_oe_n)
    if (io_oe_n != 4'hF)
      drove = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // One frame, clock runs only inside it
  task automatic frame(input logic [7:0] cmd, input int n, input int mlo, input int mhi,
                       input int s0, input int w, output logic [63:0] rx);
    rx = '0;
    drove = 1'b0;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      if (i < 8)
        drv_q = {3'h0, cmd[7 - i]};
      else if (i >= s0)
        drv_q = ~drv_q;
      else
        drv_q = (i >= mlo && i < mhi) ? 4'hF : 4'h0;
      #24 spi_sck = 1'b1;
      if (i >= s0 && w == 4)
        rx = {rx[59:0], io_in};
      else if (i >= s0 && w == 2)
        rx = {rx[61:0], io_in[1:0]};
      else if (i >= s0)
        rx = {rx[62:0], io_in[1]};
      #24 spi_sck = 1'b0;
    end
    #24 spi_cs_n = 1'b1;
    #400;
  endtask : frame
endmodule : fsp_host

`default_nettype wire
